/* File: logic/vfhs_framer.sv */
`timescale 1ns/1ps
`default_nettype none
`include "vfhs_defs.svh"
module vfhs_framer import vfhs_pkg::*; (
  // Clock and reset.
  input wire logic i_clock,
  input wire logic i_rstn,
  // APB slave.
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic [31:0] o_prdata,
  // Timing reference tick and payload source.
  input wire logic i_ntr_tick,
  input wire logic [7:0] i_pay_octet,
  output logic o_pay_take,
  // Line octet stream.
  output logic [7:0] o_tx_octet,
  output logic o_tx_valid,
  output logic o_frame_start
);
  vfhs_scr_if hscr ();
  vfhs_scr_if fscr ();
  vfhs_scr_if sscr ();
  vfhs_scrambler u_hscr (.i_clock(i_clock), .i_rstn(i_rstn), .s(hscr));
  vfhs_scrambler u_fscr (.i_clock(i_clock), .i_rstn(i_rstn), .s(fscr));
  vfhs_scrambler u_sscr (.i_clock(i_clock), .i_rstn(i_rstn), .s(sscr));

  // Field multiply, reduced by the primitive polynomial.
  function automatic logic [7:0] gf_mul(input logic [7:0] a,
                                        input logic [7:0] b);
    logic [7:0] r;
    logic [7:0] t;
    r = 8'h00;
    t = a;
    for (int k = 0; k < 8; k++) begin
      if (b[k]) r = r ^ t;
      t = {t[6:0], 1'b0} ^ (t[7] ? `VFHS_GF_POLY : 8'h00);
    end
    return r;
  endfunction

  // Remainder of the message times D^4, first message bit first.
  function automatic logic [3:0] crc4(input logic [23:0] m);
    logic [3:0] r;
    r = 4'h0;
    for (int k = 23; k >= 0; k--) begin
      r = {r[2:0], 1'b0} ^ ((m[k] ^ r[3]) ? `VFHS_CRC_POLY : 4'h0);
    end
    return r;
  endfunction

  // Reference periods between markers: 768 over gcd(768, N).
  function automatic logic [9:0] ntr_per(input logic [9:0] n);
    logic [9:0] p;
    logic run;
    p = `VFHS_NTR_BASE;
    run = 1'b1;
    for (int k = 0; k < 8; k++) begin
      if (run && !n[k]) p = p >> 1;
      else run = 1'b0;
    end
    // The factor three stays in the period unless N cancels it.
    if ((n % 10'h003) != 10'h000) p = 10'(p + (p << 1));
    return p;
  endfunction

  // Octet kind at a frame position for Fast length f and parity rf.
  function automatic vfhs_seg_t seg_of(input logic [8:0] pos,
                                       input logic [7:0] f,
                                       input logic [4:0] rf);
    logic [8:0] h;
    h = 9'(pos - `VFHS_HDR_LEN);
    if (h >= `VFHS_HALF) h = 9'(h - `VFHS_HALF);
    if (pos == 9'h000) return SG_FRAME_SYNC_OCTET_ONE;
    if (pos == 9'h001) return SG_FRAME_SYNC_OCTET_TWO;
    if (pos < `VFHS_HDR_LEN) return SG_CTRL;
    if (h < {1'b0, f}) begin
      return (h < 9'({1'b0, f} - {4'h0, rf})) ? SG_FDATA : SG_FPAR;
    end
    return (h < 9'(`VFHS_HALF - `VFHS_SLOW_PAR)) ? SG_SDATA : SG_SPAR;
  endfunction

  // Registers.
  logic en_ff, dual_ff, office_ff;
  logic [7:0] fl_ff;
  logic [4:0] rf_ff;
  logic [31:0] ind_ff;
  logic [9:0] ntr_n_ff, ntr_cnt_ff;
  logic ntr_pend_ff, inj_slow_ff, inj_fast_ff;
  logic [15:0] frm_cnt_ff;
  logic pready_ff, pslverr_ff;
  logic [31:0] prdata_ff;
  vfhs_state_t st_ff, nxt_st;
  vfhs_seg_t seg, prev_seg_ff;
  logic [8:0] pos_ff, nxt_pos;
  logic [4:0] step_ff;
  logic [7:0] alpha_ff;
  logic [7:0] g_ff [0:16];
  logic [7:0] gf_ff [0:15];
  logic [7:0] ps_ff [0:15];
  logic [7:0] pf_ff [0:15];
  logic [23:0] hdr_ff;
  logic [7:0] tx_octet_ff;
  logic tx_valid_ff, frame_start_ff, take_ff;

  // Effective frame shape; a bad dual setting falls back to single.
  logic cfg_ok, acc, wr, cfg_wr, run, bld, slow_first, fast_first;
  logic [7:0] eff_f;
  logic [4:0] eff_rf, rf_top;
  // Fast length even 2..180, parity 0/2/4/16, not above length.
  assign cfg_ok = !fl_ff[0] && fl_ff >= 8'h02 && fl_ff <= `VFHS_FAST_MAX &&
                  (rf_ff == 5'h00 || rf_ff == 5'h02 || rf_ff == 5'h04 ||
                   rf_ff == 5'h10) && {3'h0, rf_ff} <= fl_ff;
  // single latency uses no Fast octets at all.
  assign eff_f = (dual_ff && cfg_ok) ? fl_ff : 8'h00;
  assign eff_rf = (dual_ff && cfg_ok) ? rf_ff : 5'h00;
  assign rf_top = 5'(eff_rf - 5'h01);
  assign run = st_ff == ST_RUN;
  assign bld = st_ff == ST_BUILD;
  assign seg = seg_of(pos_ff, eff_f, eff_rf);
  assign slow_first = run && seg == SG_SPAR && prev_seg_ff != SG_SPAR;
  assign fast_first = run && seg == SG_FPAR && prev_seg_ff != SG_FPAR;
  assign acc = i_psel && i_penable && pready_ff;
  assign wr = acc && i_pwrite;
  assign cfg_wr = wr && i_paddr == `VFHS_A_CTRL;

  // APB handshake: one access cycle, answer prepared in setup.
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h00000000;
    end else begin
      pready_ff <= i_psel && !i_penable;
      if (i_psel && !i_penable) begin
        pslverr_ff <= 1'b0;
        prdata_ff <= 32'h00000000;
        case (i_paddr)
          `VFHS_A_CTRL: prdata_ff <= {11'h000, rf_ff, fl_ff, 5'h00,
                                      office_ff, dual_ff, en_ff};
          `VFHS_A_IND: prdata_ff <= ind_ff;
          `VFHS_A_NTR: prdata_ff <= {22'h000000, ntr_n_ff};
          `VFHS_A_INJ: prdata_ff <= {30'h00000000, inj_fast_ff, inj_slow_ff};
          `VFHS_A_STAT: prdata_ff <= {frm_cnt_ff, 13'h0000, run,
                                      dual_ff && !cfg_ok, bld};
          default: pslverr_ff <= 1'b1;
        endcase
      end
    end
  end

  // Configuration and indicator registers.
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      en_ff <= 1'b0;
      dual_ff <= 1'b0;
      office_ff <= 1'b0;
      fl_ff <= 8'h00;
      rf_ff <= 5'h00;
      ind_ff <= 32'h00000000;
      ntr_n_ff <= 10'h000;
    end else begin
      if (cfg_wr) begin
        en_ff <= i_pwdata[`VFHS_CTRL_EN];
        dual_ff <= i_pwdata[`VFHS_CTRL_DUAL];
        office_ff <= i_pwdata[`VFHS_CTRL_OFFICE];
        fl_ff <= i_pwdata[`VFHS_CTRL_F_LSB +: 8];
        rf_ff <= i_pwdata[`VFHS_CTRL_RF_LSB +: 5];
      end
      // indicator levels are taken as written: 1 flags a defect.
      if (wr && i_paddr == `VFHS_A_IND) ind_ff <= i_pwdata & `VFHS_IND_MASK;
      if (wr && i_paddr == `VFHS_A_NTR) ntr_n_ff <= i_pwdata[9:0];
    end
  end

  // corruption requests: a new request wins over completion.
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      inj_slow_ff <= 1'b0;
      inj_fast_ff <= 1'b0;
    end else begin
      inj_slow_ff <= (inj_slow_ff && !slow_first) ||
                     (wr && i_paddr == `VFHS_A_INJ && i_pwdata[0]);
      inj_fast_ff <= (inj_fast_ff && !fast_first && eff_rf != 5'h00) ||
                     (wr && i_paddr == `VFHS_A_INJ && i_pwdata[1]);
    end
  end

  // count reference ticks and arm a marker each marker period.
  always_ff @(posedge i_clock) begin
    if (!i_rstn || !office_ff) begin
      ntr_cnt_ff <= 10'h000;
      ntr_pend_ff <= 1'b0;
    end else begin
      if (i_ntr_tick) begin
        if (ntr_cnt_ff >= 10'(ntr_per(ntr_n_ff) - 10'h001)) begin
          ntr_cnt_ff <= 10'h000;
        end else begin
          ntr_cnt_ff <= 10'(ntr_cnt_ff + 10'h001);
        end
      end
      ntr_pend_ff <= (ntr_pend_ff && !(run && pos_ff == 9'h000)) ||
                     (i_ntr_tick &&
                      ntr_cnt_ff >= 10'(ntr_per(ntr_n_ff) - 10'h001));
    end
  end

  // Sequencer: build the generator, then walk the frame positions.
  always_comb begin
    nxt_st = st_ff;
    nxt_pos = 9'h000;
    case (st_ff)
      ST_BUILD: if (step_ff == `VFHS_GEN_STEPS) begin
        nxt_st = en_ff ? ST_RUN : ST_IDLE;
      end
      ST_IDLE: if (en_ff) nxt_st = ST_RUN;
      ST_RUN: begin
        if (!en_ff) nxt_st = ST_IDLE;
        nxt_pos = (pos_ff == `VFHS_FRM_LAST) ? 9'h000 : 9'(pos_ff + 9'h001);
      end
      default: nxt_st = ST_IDLE;
    endcase
    if (cfg_wr) nxt_st = ST_BUILD;
    if (nxt_st != ST_RUN) nxt_pos = 9'h000;
  end

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      st_ff <= ST_BUILD;
      pos_ff <= 9'h000;
      prev_seg_ff <= SG_FRAME_SYNC_OCTET_ONE;
    end else begin
      st_ff <= nxt_st;
      pos_ff <= nxt_pos;
      prev_seg_ff <= seg;
    end
  end

  // multiply in (x + mu^i) one root per cycle, mu = 02.
  always_ff @(posedge i_clock) begin
    if (!i_rstn || cfg_wr) begin
      step_ff <= 5'h00;
      alpha_ff <= 8'h01;
      for (int j = 0; j <= 16; j++) g_ff[j] <= (j == 0) ? 8'h01 : 8'h00;
      for (int j = 0; j < 16; j++) gf_ff[j] <= 8'h00;
    end else if (bld && step_ff != `VFHS_GEN_STEPS) begin
      step_ff <= 5'(step_ff + 5'h01);
      alpha_ff <= gf_mul(alpha_ff, 8'h02);
      g_ff[0] <= gf_mul(alpha_ff, g_ff[0]);
      for (int j = 1; j <= 16; j++) begin
        g_ff[j] <= g_ff[j - 1] ^ gf_mul(alpha_ff, g_ff[j]);
      end
      // the Fast generator is the partial product of eff_rf roots.
      if (step_ff == eff_rf) for (int j = 0; j < 16; j++) gf_ff[j] <= g_ff[j];
    end else if (bld && eff_rf == `VFHS_GEN_STEPS) begin
      for (int j = 0; j < 16; j++) gf_ff[j] <= g_ff[j];
    end
  end

  // Scrambler feeds: header, Fast and Slow each have their own history.
  always_comb begin
    hscr.en = 1'b0;
    fscr.en = 1'b0;
    sscr.en = 1'b0;
    hscr.din = 8'h00;
    fscr.din = i_pay_octet;
    sscr.din = i_pay_octet;
    // sync and parity octets bypass scrambling.
    // each stream advances only its own scrambler.
    if (run) begin
      case (seg)
        SG_CTRL: begin
          hscr.en = 1'b1;
          hscr.din = hdr_ff[8'(5'h17 - 5'(8 * (pos_ff - 9'h002))) -: 8];
        end
        SG_FDATA: fscr.en = 1'b1;
        SG_SDATA: sscr.en = 1'b1;
        default: hscr.en = 1'b0;
      endcase
    end
  end

  // systematic encoders: data passes, parity is the remainder.
  // parity starts from zero, the same as after implied zero octets.
  always_ff @(posedge i_clock) begin
    if (!i_rstn || cfg_wr) begin
      for (int j = 0; j < 16; j++) ps_ff[j] <= 8'h00;
      for (int j = 0; j < 16; j++) pf_ff[j] <= 8'h00;
    end else if (run) begin
      case (seg)
        SG_SDATA: begin
          ps_ff[0] <= gf_mul(sscr.dout ^ ps_ff[15], g_ff[0]);
          for (int j = 1; j < 16; j++) begin
            ps_ff[j] <= ps_ff[j - 1] ^ gf_mul(sscr.dout ^ ps_ff[15], g_ff[j]);
          end
        end
        SG_SPAR: begin
          ps_ff[0] <= 8'h00;
          for (int j = 1; j < 16; j++) ps_ff[j] <= ps_ff[j - 1];
        end
        SG_FDATA: if (eff_rf != 5'h00) begin
          pf_ff[0] <= gf_mul(fscr.dout ^ pf_ff[rf_top[3:0]], gf_ff[0]);
          for (int j = 1; j < 16; j++) begin
            pf_ff[j] <= pf_ff[j - 1] ^
                        gf_mul(fscr.dout ^ pf_ff[rf_top[3:0]], gf_ff[j]);
          end
        end
        SG_FPAR: begin
          pf_ff[0] <= 8'h00;
          for (int j = 1; j < 16; j++) pf_ff[j] <= pf_ff[j - 1];
        end
        default: pf_ff[0] <= pf_ff[0];
      endcase
    end
  end

  // Header capture at the first sync octet.
  // check bits come from the unscrambled control octets.
  // marker bit is bit 0 of the first control octet.
  // only the office side sets the marker.
  always_ff @(posedge i_clock) begin
    logic [23:0] raw;
    logic [3:0] c;
    raw = {ind_ff[6:0], ntr_pend_ff && office_ff, 1'b0, ind_ff[13:8],
           2'h0, ind_ff[21:16], 1'b0};
    // remainder over the message with check slots zeroed.
    c = crc4(raw & `VFHS_CRC_MASK);
    if (!i_rstn) begin
      hdr_ff <= 24'h000000;
    end else if (run && pos_ff == 9'h000) begin
      // check bits around the indicator fields.
      hdr_ff <= {raw[23:16], c[3], raw[14:9], c[2], c[1], raw[6:1], c[0]};
    end
  end

  // Output octet, one per clock while running.
  // octets leave whole; the line side sends bit 7 first.
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      tx_octet_ff <= 8'h00;
      tx_valid_ff <= 1'b0;
      frame_start_ff <= 1'b0;
      take_ff <= 1'b0;
      frm_cnt_ff <= 16'h0000;
    end else begin
      tx_valid_ff <= run;
      frame_start_ff <= run && pos_ff == 9'h000;
      // Fast and Slow codeword data, channel octets included, come from the user.
      take_ff <= nxt_st == ST_RUN &&
                 (seg_of(nxt_pos, eff_f, eff_rf) == SG_FDATA ||
                  seg_of(nxt_pos, eff_f, eff_rf) == SG_SDATA);
      if (run && pos_ff == 9'h000) frm_cnt_ff <= 16'(frm_cnt_ff + 16'h0001);
      case (seg)
        // fixed sync pair heads every frame.
        // the receiver can hunt for it at expected positions.
        SG_FRAME_SYNC_OCTET_ONE: tx_octet_ff <= `VFHS_FRAME_SYNC_OCTET_ONE;
        SG_FRAME_SYNC_OCTET_TWO: tx_octet_ff <= `VFHS_FRAME_SYNC_OCTET_TWO;
        SG_CTRL: tx_octet_ff <= hscr.dout;
        SG_FDATA: tx_octet_ff <= fscr.dout;
        SG_SDATA: tx_octet_ff <= sscr.dout;
        // first parity octet is inverted when a request is pending.
        SG_FPAR: tx_octet_ff <= pf_ff[rf_top[3:0]] ^
                                ((fast_first && inj_fast_ff) ? 8'hFF : 8'h00);
        SG_SPAR: tx_octet_ff <= ps_ff[15] ^
                                ((slow_first && inj_slow_ff) ? 8'hFF : 8'h00);
        default: tx_octet_ff <= 8'h00;
      endcase
    end
  end

  assign o_pready = pready_ff;
  assign o_pslverr = pslverr_ff;
  assign o_prdata = prdata_ff;
  assign o_pay_take = take_ff;
  assign o_tx_octet = tx_octet_ff;
  assign o_tx_valid = tx_valid_ff;
  assign o_frame_start = frame_start_ff;

  // Helper for assertions: cycles since the last frame start.
  logic [8:0] gap_ff;
  logic seen_ff;
  logic [7:0] slow_top;
  assign slow_top = ps_ff[15];
  always_ff @(posedge i_clock) begin
    if (!i_rstn || !tx_valid_ff) begin
      gap_ff <= 9'h000;
      seen_ff <= 1'b0;
    end else begin
      gap_ff <= frame_start_ff ? 9'h001 : 9'(gap_ff + 9'h001);
      seen_ff <= seen_ff || frame_start_ff;
    end
  end

  AST_SYNC: assert property (@(posedge i_clock) disable iff (!i_rstn)
    o_frame_start |-> o_tx_octet == 8'hF6 ##1 o_tx_octet == 8'h28)
    else $error("Frame does not open with the sync pair.");
  AST_FRAME_LEN: assert property (@(posedge i_clock) disable iff (!i_rstn)
    o_frame_start && seen_ff && o_tx_valid |-> gap_ff == 9'h195)
    else $error("Frame length is not 405 octets.");
  AST_CRC: assert property (@(posedge i_clock) disable iff (!i_rstn)
    o_frame_start |-> crc4(hdr_ff & 24'hFF7E7E) ==
      {hdr_ff[15], hdr_ff[8], hdr_ff[7], hdr_ff[0]})
    else $error("Header check bits do not match the control octets.");
  AST_NTR: assert property (@(posedge i_clock) disable iff (!i_rstn)
    o_frame_start && hdr_ff[16] |-> office_ff)
    else $error("Marker bit set on a remote-side device.");
  AST_BUILD: assert property (@(posedge i_clock) disable iff (!i_rstn)
    $rose(bld) && !cfg_wr |-> ##16 bld ##1 !bld)
    else $error("Generator build does not take 17 cycles.");
  AST_INJ: assert property (@(posedge i_clock) disable iff (!i_rstn)
    slow_first && inj_slow_ff && !cfg_wr |=> o_tx_octet == ~$past(slow_top))
    else $error("Requested parity corruption not applied.");
  AST_APB_RDY: assert property (@(posedge i_clock) disable iff (!i_rstn)
    i_psel && !i_penable |=> o_pready)
    else $error("Access phase without ready.");
  COV_FRAME: cover property (@(posedge i_clock) disable iff (!i_rstn)
    o_frame_start && seen_ff);
  COV_DUAL: cover property (@(posedge i_clock) disable iff (!i_rstn)
    run && seg == SG_FPAR);
  COV_MARK: cover property (@(posedge i_clock) disable iff (!i_rstn)
    o_frame_start && hdr_ff[16]);
  COV_INJ: cover property (@(posedge i_clock) disable iff (!i_rstn)
    slow_first && inj_slow_ff);
endmodule
`default_nettype wire

/* File: logic/vfhs_defs.svh */
`ifndef VFHS_DEFS_SVH
`define VFHS_DEFS_SVH
// Frame layout, in octets.
`define VFHS_FRAME_SYNC_OCTET_ONE 8'hF6
`define VFHS_FRAME_SYNC_OCTET_TWO 8'h28
`define VFHS_HDR_LEN 9'h005
`define VFHS_FRM_LAST 9'h194
`define VFHS_HALF 9'h0C8
`define VFHS_SLOW_PAR 9'h010
`define VFHS_FAST_MAX 8'hB4
`define VFHS_GEN_STEPS 5'h10
// Field arithmetic and header check.
`define VFHS_GF_POLY 8'h1D
`define VFHS_CRC_POLY 4'h3
`define VFHS_CRC_MASK 24'hFF7E7E
// Timing reference: 768 periods is 256 times 3.
`define VFHS_NTR_BASE 10'h100
// Scrambler taps as history indices (n-18 and n-23).
`define VFHS_SCR_TAP_A 17
`define VFHS_SCR_TAP_B 22
// Register byte addresses.
`define VFHS_A_CTRL 12'h000
`define VFHS_A_IND 12'h004
`define VFHS_A_NTR 12'h008
`define VFHS_A_INJ 12'h00C
`define VFHS_A_STAT 12'h010
// Field positions and masks.
`define VFHS_CTRL_EN 0
`define VFHS_CTRL_DUAL 1
`define VFHS_CTRL_OFFICE 2
`define VFHS_CTRL_F_LSB 8
`define VFHS_CTRL_RF_LSB 16
`define VFHS_IND_MASK 32'h003F3F7F
`endif

/* File: logic/vfhs_pkg.sv */
`default_nettype none
package vfhs_pkg;
  // Sequencer states.
  typedef enum logic [1:0] {ST_IDLE, ST_BUILD, ST_RUN} vfhs_state_t;
  // Kind of octet at a frame position.
  typedef enum logic [2:0] {
    SG_FRAME_SYNC_OCTET_ONE, SG_FRAME_SYNC_OCTET_TWO, SG_CTRL, SG_FDATA, SG_FPAR, SG_SDATA, SG_SPAR
  } vfhs_seg_t;
endpackage
`default_nettype wire

/* File: logic/vfhs_scr_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface vfhs_scr_if;
  logic en;
  logic [7:0] din;
  logic [7:0] dout;
  modport scr (input en, input din, output dout);
  modport user (output en, output din, input dout);
endinterface
`default_nettype wire

/* File: logic/vfhs_scrambler.sv */
`timescale 1ns/1ps
`default_nettype none
`include "vfhs_defs.svh"
module vfhs_scrambler import vfhs_pkg::*; (
  // Clock and reset.
  input wire logic i_clock,
  input wire logic i_rstn,
  // Octet in and scrambled octet out.
  vfhs_scr_if.scr s
);
  logic [22:0] hist_ff;
  logic [22:0] nxt_hist;
  logic [7:0] nxt_out;

  // self-synchronous recursion: each bit mixes in outputs 18 and 23 back.
  always_comb begin
    logic b;
    b = 1'b0;
    nxt_hist = hist_ff;
    nxt_out = 8'h00;
    for (int k = 7; k >= 0; k--) begin
      b = s.din[k] ^ nxt_hist[`VFHS_SCR_TAP_A] ^ nxt_hist[`VFHS_SCR_TAP_B];
      nxt_out[k] = b;
      nxt_hist = {nxt_hist[21:0], b};
    end
    s.dout = nxt_out;
  end

  // history cleared at reset, advanced only for processed octets.
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      hist_ff <= 23'h000000;
    end else if (s.en) begin
      hist_ff <= nxt_hist;
    end
  end

  AST_SCR_HOLD: assert property (@(posedge i_clock) disable iff (!i_rstn)
    !s.en |=> $stable(hist_ff))
    else $error("Scrambler history moved without an octet.");
  AST_SCR_FIRST: assert property (@(posedge i_clock) disable iff (!i_rstn)
    s.en |-> s.dout[7] == (s.din[7] ^ hist_ff[17] ^ hist_ff[22]))
    else $error("Scrambler first bit does not follow the recursion.");
endmodule
`default_nettype wire

/* File: verification/vfhs_peer_rx.sv */
`timescale 1ns/1ps
`default_nettype none
module vfhs_peer_rx (
  // Clock and reset.
  input wire logic i_clock,
  input wire logic i_rstn,
  // Line octet stream.
  input wire logic [7:0] i_octet,
  input wire logic i_valid,
  input wire logic i_start,
  // Recovered control octets and header checks.
  output logic [23:0] o_ctrl,
  output logic o_sync_ok,
  output logic o_crc_ok,
  // Slow payload order broken in the current single-class frame.
  output logic o_pay_bad
);
  logic [22:0] hist_ff;
  logic [8:0] pos_ff;
  logic [8:0] idx;
  logic [7:0] prev_ff;
  logic [23:0] msg;
  logic [3:0] rem;
  logic [22:0] shist_ff;
  logic [7:0] sprev_ff;
  logic [30:0] sd;
  logic sdata;

  // undo scrambling, first sent bit first.
  function automatic logic [30:0] dscr(input logic [22:0] h,
                                       input logic [7:0] o);
    logic [7:0] d;
    for (int i = 7; i >= 0; i--) begin
      d[i] = o[i] ^ h[17] ^ h[22];
      h = {h[21:0], o[i]};
    end
    return {h, d};
  endfunction

  assign msg = o_ctrl & 24'hFF7E7E;
  always_comb begin
    rem = 4'h0;
    for (int i = 23; i >= 0; i--) begin
      rem = {rem[2:0], 1'b0} ^ ({4{rem[3] ^ msg[i]}} & 4'h3);
    end
  end
  assign o_crc_ok = rem == {o_ctrl[15], o_ctrl[8], o_ctrl[7], o_ctrl[0]};

  // frame position follows the sync pulse.
  assign idx = i_start ? 9'h000 : pos_ff;

  // single-class Slow data positions, descrambled in order.
  assign sdata = (idx >= 9'h005 && idx <= 9'h0BC) ||
                 (idx >= 9'h0CD && idx <= 9'h184);
  assign sd = dscr(shist_ff, i_octet);

  // header descrambler, cleared only by reset.
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      hist_ff <= 23'h000000;
      pos_ff <= 9'h000;
      prev_ff <= 8'h00;
      o_ctrl <= 24'h000000;
      o_sync_ok <= 1'b0;
      shist_ff <= 23'h000000;
      sprev_ff <= 8'h00;
      o_pay_bad <= 1'b0;
    end else if (i_valid) begin
      pos_ff <= idx + 9'h001;
      prev_ff <= i_octet;
      if (i_start) o_pay_bad <= 1'b0;
      // The first four octets go unchecked while the history reseeds.
      if (sdata) begin
        {shist_ff, sprev_ff} <= sd;
        if (idx >= 9'h009 && sd[7:0] != 8'(sprev_ff + 8'h01)) begin
          o_pay_bad <= 1'b1;
        end
      end
      if (idx == 9'h001) begin
        o_sync_ok <= prev_ff == 8'hF6 && i_octet == 8'h28;
      end
      if (idx >= 9'h002 && idx <= 9'h004) begin
        {hist_ff, o_ctrl[7:0]} <= dscr(hist_ff, i_octet);
        o_ctrl[23:8] <= o_ctrl[15:0];
      end
    end
  end
endmodule
`default_nettype wire

/* File: verification/vfhs_framer_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module vfhs_framer_tb;
  logic clk, rstn, psel, penable, pwrite, tick, er;
  logic pready, pslverr, take, tvalid, fstart, sync_ok, crc_ok, pbad;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] pay, tx;
  logic [23:0] ctrl, hdr;
  int err_total = 0;
  int num_checks = 0;
  int takes;

  // Free-running 25 MHz clock.
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  vfhs_framer uut (.i_clock(clk), .i_rstn(rstn), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_pready(pready), .o_pslverr(pslverr),
    .o_prdata(prdata), .i_ntr_tick(tick), .i_pay_octet(pay),
    .o_pay_take(take), .o_tx_octet(tx), .o_tx_valid(tvalid),
    .o_frame_start(fstart));
  vfhs_peer_rx peer (.i_clock(clk), .i_rstn(rstn), .i_octet(tx),
    .i_valid(tvalid), .i_start(fstart), .o_ctrl(ctrl),
    .o_sync_ok(sync_ok), .o_crc_ok(crc_ok), .o_pay_bad(pbad));

  // Payload source steps on every consumed octet.
  always @(posedge clk) if (take === 1'b1) pay <= pay + 8'h01;

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // Only the watchdog ends a wait for the slave's answer.
    while (pready !== 1'b1) @(posedge clk);
    cmp(pready, 1'b1, "no bus answer");
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic frame();
    int n;
    n = 0;
    takes = 0;
    while (fstart !== 1'b1 && n < 1000) begin
      @(posedge clk);
      n++;
    end
    for (int j = 0; j < 405; j++) begin
      if (j == 0) cmp(tx, 8'hF6, "first sync octet");
      if (j == 1) cmp(tx, 8'h28, "second sync octet");
      if (j == 6) hdr = ctrl;
      takes += (take === 1'b1);
      cmp(tvalid, 1'b1, "stream gap");
      @(posedge clk);
    end
    cmp(fstart, 1'b1, "frame length");
    cmp(sync_ok & crc_ok, 1'b1, "header check");
  endtask

  task automatic t_reset();
    cmp(tvalid, 1'b0, "stream after reset");
    apb(1'b0, 12'h000, 32'h0);
    cmp(rd, 32'h0, "control reset value");
    apb(1'b0, 12'h014, 32'h0);
    cmp(er, 1'b1, "unmapped error");
    cmp(rd, 32'h0, "unmapped data");
    $display("test reset done");
  endtask

  task automatic t_class();
    logic [31:0] cfg [6] = '{32'h1, 32'h00080C03, 32'h00020203,
                             32'h0004B403, 32'h00101403, 32'h0008B503};
    int exp [6] = '{368, 368, 364, 360, 336, 368};
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, 12'h000, cfg[i]);
      frame();
      cmp(takes, exp[i], "octets taken");
      if (exp[i] == 368) cmp(pbad, 1'b0, "slow payload order");
    end
    apb(1'b0, 12'h010, 32'h0);
    cmp(rd[2:0], 3'b110, "status of a bad dual setting");
    apb(1'b0, 12'h000, 32'h0);
    cmp(rd, 32'h0008B503, "control readback");
    $display("test class done");
  endtask

  task automatic t_ind();
    logic [31:0] ind [3] = '{32'h003F3F7F, 32'h00152A55, 32'h0};
    logic [23:0] e;
    apb(1'b1, 12'h000, 32'h1);
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, 12'h004, ind[i]);
      frame();
      frame();
      e = {ind[i][6:0], 2'b00, ind[i][13:8], 2'b00, ind[i][21:16], 1'b0};
      cmp(hdr & 24'hFF7E7E, e, "control octets");
    end
    $display("test indicators done");
  endtask

  task automatic t_ntr();
    int hits;
    apb(1'b1, 12'h008, 32'h300);
    apb(1'b1, 12'h000, 32'h5);
    frame();
    for (int k = 0; k < 3; k++) begin
      tick <= 1'b1;
      @(posedge clk);
      tick <= 1'b0;
      hits = 0;
      repeat (3) begin
        frame();
        hits += hdr[16];
      end
      cmp(hits, (k == 1) ? 0 : 1, "marker count");
      if (k == 0) apb(1'b1, 12'h008, 32'h180);
    end
    $display("test marker done");
  endtask

  task automatic t_inj();
    apb(1'b1, 12'h000, 32'h1);
    apb(1'b1, 12'h00C, 32'h1);
    apb(1'b0, 12'h00C, 32'h0);
    cmp(rd[1:0], 2'b01, "slow request pending");
    frame();
    apb(1'b0, 12'h00C, 32'h0);
    cmp(rd[1:0], 2'b00, "slow request served");
    apb(1'b1, 12'h00C, 32'h2);
    apb(1'b0, 12'h00C, 32'h0);
    cmp(rd[1:0], 2'b00, "fast request dropped");
    apb(1'b1, 12'h000, 32'h00101403);
    apb(1'b1, 12'h00C, 32'h2);
    apb(1'b0, 12'h00C, 32'h0);
    cmp(rd[1:0], 2'b10, "fast request pending");
    frame();
    apb(1'b0, 12'h00C, 32'h0);
    cmp(rd[1:0], 2'b00, "fast request served");
    $display("test corruption done");
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Main sequence after a 12-cycle reset.
  initial begin
    {rstn, psel, penable, pwrite, tick} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    pay = 8'h00;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_reset();
    t_class();
    t_ind();
    t_ntr();
    t_inj();
    test_done();
  end

  // Watchdog against a hung stream or bus.
  initial begin
    repeat (40000) @(posedge clk);
    $display("unexpected at %0t: watchdog expired", $time);
    err_total++;
    test_done();
  end
endmodule
`default_nettype wire
